// ---- include/nco_clk_if.sv ----
`timescale 1ns/1ps
//----------------------------------------------------------------------
// input clock edge carrier
//----------------------------------------------------------------------
// Purpose: carries source select and edge strobes between core and
//          clock source front end
// Assumes: all signals on sys_clk
// Notes:   rise and fall are one-cycle pulses from the pins; both stay high every cycle on the system source
interface nco_clk_if;
   logic [1:0] sel;
   logic       rise;
   logic       fall;
   modport core (output sel, input rise, input fall);
   modport src  (input sel, output rise, output fall);
endinterface : nco_clk_if

// ---- include/nco_pkg.sv ----
//----------------------------------------------------------------------
// numerically controlled oscillator: shared constants
//----------------------------------------------------------------------
// Purpose: offsets, field positions, reset values and widths of the
//          phase accumulator block
// Assumes: byte-wide registers, one per aligned APB word
// Notes:   unused upper bits of every word read as zero
package nco_pkg;
   localparam int          ACC_W        = 20;
   localparam int          PCNT_W       = 8;
   localparam int          ADDR_W       = 12;
   // register byte addresses
   localparam logic [11:0] OFS_CTRL     = 12'h000;
   localparam logic [11:0] OFS_CLKSEL   = 12'h004;
   localparam logic [11:0] OFS_ACC_L    = 12'h008;
   localparam logic [11:0] OFS_ACC_H    = 12'h00c;
   localparam logic [11:0] OFS_ACC_U    = 12'h010;
   localparam logic [11:0] OFS_STEP_L   = 12'h014;
   localparam logic [11:0] OFS_STEP_H   = 12'h018;
   localparam logic [11:0] OFS_STEP_U   = 12'h01c;
   localparam logic [11:0] OFS_FLAG     = 12'h020;
   // field positions
   localparam int          CTRL_EN_BIT  = 7;
   localparam int          CTRL_OUT_BIT = 5;
   localparam int          CTRL_POL_BIT = 4;
   localparam int          CTRL_PFM_BIT = 0;
   localparam int          CLK_PWS_LSB  = 5;
   localparam int          CLK_CKS_LSB  = 0;
   localparam int          FLAG_BIT     = 0;
   // reset values
   localparam logic [7:0]  CTRL_RST     = 8'h00;
   localparam logic [7:0]  CLKSEL_RST   = 8'h00;
   localparam logic [19:0] ACC_RST      = 20'h00000;
   localparam logic [19:0] STEP_RST     = 20'h00001;
   // clock source codes
   localparam logic [1:0]  CKS_PIN_A    = 2'h0;
   localparam logic [1:0]  CKS_SYS      = 2'h1;
   localparam logic [1:0]  CKS_PIN_C    = 2'h2;
endpackage : nco_pkg

// ---- rtl/nco_clksrc.sv ----
`timescale 1ns/1ps
//----------------------------------------------------------------------
// input clock source front end
//----------------------------------------------------------------------
// Purpose: synchronise the oscillator input pins and turn the selected
//          source into rise and fall enables
// Assumes: pin sources run well below half of sys_clk
// Notes:   the system source gives both edges every cycle
module nco_clksrc
   import nco_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic osc_pin_a,
   input  wire logic osc_pin_c,
   nco_clk_if.src    ck
);
   typedef struct packed {
      logic a_meta;
      logic a_sync;
      logic c_meta;
      logic c_sync;
      logic prev;
   } nco_src_s;

   nco_src_s st_ff;
   nco_src_s nxt_st;
   logic     cur;

   // selected synchronised level; meta stages feed only sync stages
   always_comb begin
      case (ck.sel)
         CKS_PIN_A: cur = st_ff.a_sync;
         CKS_PIN_C: cur = st_ff.c_sync;
         default:   cur = st_ff.prev;
      endcase
   end

   // two-flop synchronisers and edge history
   always_comb begin
      nxt_st        = st_ff;
      nxt_st.a_meta = osc_pin_a;
      nxt_st.a_sync = st_ff.a_meta;
      nxt_st.c_meta = osc_pin_c;
      nxt_st.c_sync = st_ff.c_meta;
      nxt_st.prev   = cur;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // switching source may give one stray edge; reprogram while disabled
   assign ck.rise = (ck.sel == CKS_SYS) | (cur & ~st_ff.prev);
   assign ck.fall = (ck.sel == CKS_SYS) | (~cur & st_ff.prev);
endmodule : nco_clksrc

// ---- rtl/nco_core.sv ----
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
//----------------------------------------------------------------------
// numerically controlled oscillator core
//----------------------------------------------------------------------
// Purpose: 20-bit phase accumulator with double-buffered increment,
//          output stage and overflow flag behind an APB slave
// Assumes: input clock edges arrive as enables from nco_clksrc
// Notes:   zero wait state bus; read data captured in the setup cycle
module nco_core
   import nco_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        osc_pin_a,
   input  wire logic        osc_pin_c,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             nco_out,
   output logic             overflow_pulse,
   output logic             overflow_irq_flag
);
   //-------------------------------------------------------------------
   // state
   //-------------------------------------------------------------------
   typedef struct packed {
      logic              en;
      logic              pol;
      logic              pfm;
      logic [2:0]        pws;
      logic [1:0]        cks;
      logic [ACC_W-1:0]  acc;
      logic [ACC_W-1:0]  step;
      logic [ACC_W-1:0]  stepbuf;
      logic              ld_pend;
      logic              raw;
      logic              outq;
      logic [PCNT_W-1:0] pcnt;
      logic              flag;
      logic              ovf;
      logic [7:0]        rdat;
      logic              slverr;
   } nco_state_s;

   nco_state_s      st_ff;
   nco_state_s      nxt_st;
   logic [ACC_W:0]  sum;
   logic            adv;
   logic            carry;
   logic            wr;
   logic            setup;
   logic [7:0]      wbyte;

   nco_clk_if ck ();

   //-------------------------------------------------------------------
   // clock source front end
   //-------------------------------------------------------------------
   nco_clksrc u_src (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .osc_pin_a (osc_pin_a),
      .osc_pin_c (osc_pin_c),
      .ck        (ck.src)
   );

   assign ck.sel = st_ff.cks;

   //-------------------------------------------------------------------
   // decode helpers
   //-------------------------------------------------------------------
   // true for any address that holds a register
   function automatic logic is_mapped(input logic [11:0] a);
      case (a)
         OFS_CTRL, OFS_CLKSEL, OFS_ACC_L, OFS_ACC_H, OFS_ACC_U,
         OFS_STEP_L, OFS_STEP_H, OFS_STEP_U, OFS_FLAG: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction : is_mapped

   // read view of one register; unused bits come back as zero
   function automatic logic [7:0] rd_byte(input nco_state_s s,
                                          input logic [11:0] a);
      logic [7:0] r;
      r = 8'h00;
      case (a)
         OFS_CTRL: begin
            r[CTRL_EN_BIT]  = s.en;
            r[CTRL_OUT_BIT] = s.outq;
            r[CTRL_POL_BIT] = s.pol;
            r[CTRL_PFM_BIT] = s.pfm;
         end
         OFS_CLKSEL: begin
            r[CLK_PWS_LSB +: 3] = s.pws;
            r[CLK_CKS_LSB +: 2] = s.cks;
         end
         OFS_ACC_L:  r = s.acc[7:0];
         OFS_ACC_H:  r = s.acc[15:8];
         OFS_ACC_U:  r = {4'h0, s.acc[19:16]};
         OFS_STEP_L: r = s.step[7:0];
         OFS_STEP_H: r = s.step[15:8];
         OFS_STEP_U: r = {4'h0, s.step[19:16]};
         OFS_FLAG:   r[FLAG_BIT] = s.flag;
         default:    r = 8'h00;
      endcase
      return r;
   endfunction : rd_byte

   // pulse length in input periods for a width code
   function automatic logic [PCNT_W-1:0] pulse_len(input logic [2:0] c);
      return PCNT_W'(1) << c;
   endfunction : pulse_len

   //-------------------------------------------------------------------
   // adder
   //-------------------------------------------------------------------
   // carry out of bit 19 is the overflow event
   assign sum   = {1'b0, st_ff.acc} + {1'b0, st_ff.stepbuf};
   assign adv   = st_ff.en & ck.rise;
   assign carry = adv & sum[ACC_W];

   // bus phases; a write lands only at the access edge
   assign setup = psel & ~penable;
   assign wr    = psel & penable & pwrite & pstrb[0];
   assign wbyte = pwdata[7:0];

   //-------------------------------------------------------------------
   // next state
   //-------------------------------------------------------------------
   always_comb begin
      nxt_st     = st_ff;
      nxt_st.ovf = carry;

      // accumulate on each selected input rise while enabled
      if (adv) begin
         nxt_st.acc = sum[ACC_W-1:0];
      end

      // output stage, advanced on the same input rise
      if (adv) begin
         if (st_ff.pfm) begin
            if (carry) begin
               // a fresh overflow restarts the count, so a width
               // longer than the overflow period never lets go
               nxt_st.raw  = 1'b1;
               nxt_st.pcnt = pulse_len(st_ff.pws);
            end else if (st_ff.pcnt != '0) begin
               nxt_st.pcnt = st_ff.pcnt - PCNT_W'(1);
               if (st_ff.pcnt == PCNT_W'(1)) begin
                  nxt_st.raw = 1'b0;
               end
            end
         end else if (carry) begin
            nxt_st.raw = ~st_ff.raw;
         end
      end

      // hidden buffer takes the increment on the next input fall
      if (st_ff.ld_pend && ck.fall) begin
         nxt_st.stepbuf = st_ff.step;
         nxt_st.ld_pend = 1'b0;
      end

      // register writes
      if (wr) begin
         case (paddr)
            OFS_CTRL: begin
               nxt_st.en  = wbyte[CTRL_EN_BIT];
               nxt_st.pol = wbyte[CTRL_POL_BIT];
               nxt_st.pfm = wbyte[CTRL_PFM_BIT];
            end
            OFS_CLKSEL: begin
               nxt_st.pws = wbyte[CLK_PWS_LSB +: 3];
               nxt_st.cks = wbyte[CLK_CKS_LSB +: 2];
            end
            // writes while running race the adder and win here
            OFS_ACC_L:  nxt_st.acc[7:0]   = wbyte;
            OFS_ACC_H:  nxt_st.acc[15:8]  = wbyte;
            OFS_ACC_U:  nxt_st.acc[19:16] = wbyte[3:0];
            OFS_STEP_H: nxt_st.step[15:8] = wbyte;
            OFS_STEP_U: nxt_st.step[19:16] = wbyte[3:0];
            OFS_STEP_L: begin
               nxt_st.step[7:0] = wbyte;
               // upper bytes assumed already written
               if (st_ff.en) begin
                  nxt_st.ld_pend = 1'b1;
               end else begin
                  nxt_st.stepbuf = {st_ff.step[19:8], wbyte};
                  nxt_st.ld_pend = 1'b0;
               end
            end
            OFS_FLAG: begin
               if (!wbyte[FLAG_BIT]) begin
                  nxt_st.flag = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end

      // overflow sets the flag after any clear, so set wins
      if (carry) begin
         nxt_st.flag = 1'b1;
      end

      // idle buffer follows the increment when disabled
      if (!nxt_st.en && st_ff.ld_pend) begin
         nxt_st.stepbuf = nxt_st.step;
         nxt_st.ld_pend = 1'b0;
      end

      // polarity is the last stage; read back through the control byte
      nxt_st.outq = nxt_st.raw ^ nxt_st.pol;

      // read data and error captured in setup, shown during access
      if (setup) begin
         nxt_st.rdat   = rd_byte(st_ff, paddr);
         nxt_st.slverr = ~is_mapped(paddr);
      end
   end

   //-------------------------------------------------------------------
   // state register
   //-------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_ff         <= '0;
         st_ff.en      <= CTRL_RST[CTRL_EN_BIT];
         st_ff.pol     <= CTRL_RST[CTRL_POL_BIT];
         st_ff.pfm     <= CTRL_RST[CTRL_PFM_BIT];
         st_ff.pws     <= CLKSEL_RST[CLK_PWS_LSB +: 3];
         st_ff.cks     <= CLKSEL_RST[CLK_CKS_LSB +: 2];
         st_ff.acc     <= ACC_RST;
         st_ff.step    <= STEP_RST;
         st_ff.stepbuf <= STEP_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   //-------------------------------------------------------------------
   // outputs
   //-------------------------------------------------------------------
   // read data only reflects the cycle it was captured in
   assign prdata            = {24'h000000, st_ff.rdat};
   assign pready            = 1'b1;
   assign pslverr           = psel & penable & st_ff.slverr;
   assign nco_out           = st_ff.outq;
   assign overflow_pulse    = st_ff.ovf;
   assign overflow_irq_flag = st_ff.flag;
endmodule : nco_core

// ---- verification/nco_core_properties.sv ----
`timescale 1ns/1ps
//----------------------------------------------------------------------
// port checker
//----------------------------------------------------------------------
// Purpose: bus and output relations of nco_core
// Assumes: one clock, synchronous reset
// Notes:   mode bit shadowed from bus writes
module nco_core_props
   import nco_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        nco_out,
   input wire logic        overflow_pulse,
   input wire logic        overflow_irq_flag
);
   logic acc_ph;
   logic map_ok;
   logic ctrl_wr;
   logic flag_wr;
   logic pfm_ff;
   logic nxt_pfm;
   // access phase decode
   assign acc_ph  = psel && penable;
   assign map_ok  = paddr <= OFS_FLAG && paddr[1:0] == 2'h0;
   assign ctrl_wr = acc_ph && pwrite && pstrb[0] && paddr == OFS_CTRL;
   assign flag_wr = acc_ph && pwrite && paddr == OFS_FLAG;
   // shadow of pulse mode; only a bus write can move it
   assign nxt_pfm = ctrl_wr ? pwdata[CTRL_PFM_BIT] : pfm_ff;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pfm_ff <= 1'b0;
      end else begin
         pfm_ff <= nxt_pfm;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_accu_nibble: assert property (
      acc_ph && !pwrite && paddr == OFS_ACC_U |-> prdata[31:4] == 28'h0)
      else $error("accumulator upper bits not zero");
   a_step_nibble: assert property (
      acc_ph && !pwrite && paddr == OFS_STEP_U |-> prdata[31:4] == 28'h0)
      else $error("increment upper bits not zero");
   a_byte_wide: assert property (
      acc_ph && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("read data wider than a byte");
   a_unmapped_err: assert property (
      acc_ph && !map_ok |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   a_mapped_clean: assert property (
      acc_ph && map_ok |-> !pslverr)
      else $error("mapped access refused");
   a_flag_set: assert property (
      overflow_pulse |-> ##[0:1] overflow_irq_flag)
      else $error("overflow did not set flag");
   a_flag_hold: assert property (
      overflow_irq_flag && !flag_wr |=> overflow_irq_flag)
      else $error("flag dropped without clear");
   a_flag_cause: assert property (
      $rose(overflow_irq_flag) |-> overflow_pulse || $past(overflow_pulse))
      else $error("flag rose without overflow");
   a_fdc_toggle: assert property (
      !pfm_ff && !$past(ctrl_wr) && !$past(ctrl_wr, 2)
      |-> $changed(nco_out) == overflow_pulse)
      else $error("square output not tied to overflow");
endmodule : nco_core_props

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
//----------------------------------------------------------------------
// oscillator core bench
//----------------------------------------------------------------------
// Purpose: drive nco_core over APB and its pins, judge results
// Assumes: pins toggled slowly, seven cycles per phase
// Notes:   accumulator written only while disabled
module testbench import nco_pkg::*; ;
   localparam logic [7:0] EN  = 8'h01 << CTRL_EN_BIT;
   localparam logic [7:0] PFM = 8'h01 << CTRL_PFM_BIT;
   localparam logic [7:0] POL = 8'h01 << CTRL_POL_BIT;
   localparam logic [7:0] OUT = 8'h01 << CTRL_OUT_BIT;
   logic        sys_clk;
   logic        rst;
   logic        osc_pin_a;
   logic        osc_pin_c;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        nco_out;
   logic        overflow_pulse;
   logic        overflow_irq_flag;
   logic [31:0] rd;
   logic        er;
   int          fail_count;
   int          n_checks;
   nco_core nco_core_i (
      .sys_clk(sys_clk), .rst(rst), .osc_pin_a(osc_pin_a),
      .osc_pin_c(osc_pin_c), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .nco_out(nco_out), .overflow_pulse(overflow_pulse),
      .overflow_irq_flag(overflow_irq_flag));
   //----------------------------------------------------------------
   // shared tasks
   //----------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic hang(input string nm);
      fail_count++;
      $display("[FAIL] %s expected done seen timeout", nm);
      print_verdict();
   endtask : hang
   // one apb transfer; read data taken at the pready edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
      int i;
      @(posedge sys_clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge sys_clk);
         if (pready === 1'b1) break;
      end
      if (i == 16) hang("pready");
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr3(input logic [11:0] a, input logic [19:0] v);
      apb(1'b1, a + 12'h008, {4'h0, v[19:16]});
      apb(1'b1, a + 12'h004, v[15:8]);
      apb(1'b1, a, v[7:0]);
   endtask : wr3
   task automatic pin(input logic [1:0] s, input logic l);
      @(posedge sys_clk);
      if (s == CKS_PIN_A) osc_pin_a <= l;
      else osc_pin_c <= l;
      repeat (6) @(posedge sys_clk);
   endtask : pin
   //----------------------------------------------------------------
   // scenarios
   //----------------------------------------------------------------
   task automatic t_reset();
      logic [11:0] ad [10] = '{OFS_CTRL, OFS_CLKSEL, OFS_ACC_L, OFS_ACC_H,
         OFS_ACC_U, OFS_STEP_L, OFS_STEP_H, OFS_STEP_U, OFS_FLAG, 12'h024};
      for (int i = 0; i < 10; i++) begin
         apb(1'b0, ad[i], 8'h00);
         chk("reset value", rd, {31'h0, i == 5});
         chk("bus error", er, i == 9);
      end
   endtask : t_reset
   task automatic t_bytes();
      logic [11:0] ad [6] = '{OFS_ACC_L, OFS_ACC_H, OFS_ACC_U,
         OFS_STEP_U, OFS_STEP_H, OFS_STEP_L};
      logic [7:0] wd [6] = '{8'ha5, 8'h5a, 8'hff, 8'hff, 8'hc3, 8'h3c};
      logic [7:0] ex [6] = '{8'ha5, 8'h5a, 8'h0f, 8'h0f, 8'hc3, 8'h3c};
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, ad[i], wd[i]);
         apb(1'b0, ad[i], 8'h00);
         chk("byte readback", rd, {24'h0, ex[i]});
      end
   endtask : t_bytes
   // second step written mid-run must wait for the next input fall
   task automatic t_count(input logic [1:0] s);
      logic [19:0] v;
      wr3(OFS_ACC_L, 20'h0);
      wr3(OFS_STEP_L, 20'h12345);
      apb(1'b1, OFS_CLKSEL, {6'h0, s});
      apb(1'b1, OFS_CTRL, EN);
      for (int k = 0; k < 5; k++) begin
         if (k == 3) wr3(OFS_STEP_L, 20'h00abc);
         pin(s, 1'b1);
         pin(s, 1'b0);
      end
      apb(1'b1, OFS_CTRL, 8'h00);
      for (int b = 0; b < 3; b++) begin
         apb(1'b0, OFS_ACC_L + 12'(4 * b), 8'h00);
         v[8*b +: 4] = rd[3:0];
         if (b < 2) v[8*b+4 +: 4] = rd[7:4];
      end
      chk("accumulated phase", v, 20'h497d0);
   endtask : t_count
   task automatic t_fdc();
      logic [7:0] a;
      logic       last;
      int         np;
      int         nt;
      wr3(OFS_STEP_L, 20'h00001);
      apb(1'b1, OFS_CLKSEL, {6'h0, CKS_SYS});
      apb(1'b1, OFS_CTRL, EN);
      apb(1'b0, OFS_ACC_L, 8'h00);
      a = rd[7:0];
      apb(1'b0, OFS_ACC_L, 8'h00);
      chk("live accumulator", rd[7:0] != a, 1);
      wr3(OFS_STEP_L, 20'h40000);
      repeat (8) @(posedge sys_clk);
      np = 0;
      nt = 0;
      last = nco_out;
      for (int i = 0; i < 64; i++) begin
         @(posedge sys_clk);
         np += overflow_pulse;
         nt += (nco_out != last);
         last = nco_out;
      end
      chk("overflow count", np, 16);
      chk("toggle count", nt, 16);
      apb(1'b1, OFS_CTRL, 8'h00);
      apb(1'b0, OFS_FLAG, 8'h00);
      chk("flag set", rd, 1);
      apb(1'b1, OFS_FLAG, 8'h00);
      apb(1'b1, OFS_FLAG, 8'h01);
      apb(1'b0, OFS_FLAG, 8'h00);
      chk("flag cleared", rd, 0);
   endtask : t_fdc
   // overflow every 512 rises, longer than the widest pulse
   task automatic t_pulse();
      int i;
      int w;
      wr3(OFS_STEP_L, 20'h00800);
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, OFS_CLKSEL, 8'(c << CLK_PWS_LSB) | CKS_SYS);
         apb(1'b1, OFS_CTRL, EN | PFM);
         // square mode may leave the output high; let that pulse run out
         for (i = 0; i < 700 && nco_out !== 1'b0; i++) @(posedge sys_clk);
         if (i == 700) hang("pulse idle");
         for (i = 0; i < 600 && nco_out !== 1'b1; i++) @(posedge sys_clk);
         if (i == 600) hang("pulse start");
         for (w = 0; w < 300 && nco_out === 1'b1; w++) @(posedge sys_clk);
         chk("pulse width", w, 1 << c);
         apb(1'b1, OFS_CTRL, 8'h00);
      end
      // inversion is the last stage, so it shows even while idle
      apb(1'b1, OFS_CTRL, POL);
      @(posedge sys_clk);
      chk("inverted output", nco_out, 1);
      apb(1'b0, OFS_CTRL, 8'h00);
      chk("control readback", rd, {24'h0, POL | OUT});
      apb(1'b1, OFS_CTRL, 8'h00);
   endtask : t_pulse
   //----------------------------------------------------------------
   // clock and main sequence
   //----------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   initial begin
      rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'hf;
      osc_pin_a = 1'b0;
      osc_pin_c = 1'b0;
      fail_count = 0;
      n_checks = 0;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset();
      t_bytes();
      t_count(CKS_PIN_A);
      t_count(CKS_PIN_C);
      t_fdc();
      t_pulse();
      print_verdict();
   end
endmodule : testbench
bind nco_core nco_core_props nco_core_props_i (.sys_clk(sys_clk),
   .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .pslverr(pslverr), .nco_out(nco_out), .overflow_pulse(overflow_pulse),
   .overflow_irq_flag(overflow_irq_flag));
